// [rtl/mts_sequencer.sv]
`timescale 1ns/1ps
`include "mts_defines.svh"

module mts_sequencer
  import mts_pkg::*;
#(
  parameter int DEPTH = 8,
  parameter int MEM_AW = 10
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic trig_pin_in,
  output logic meas_start,
  input wire logic rdg_valid,
  input wire logic [31:0] rdg_data
);

  localparam int CW = $clog2(DEPTH + 1);
  localparam int HW = $clog2(DEPTH);

  typedef struct packed {
    mts_state_type st;
    mts_src_type src;
    logic [23:0] samp_cnt;
    logic [23:0] trig_cnt;
    logic [23:0] delay_us;
    logic scan;
    logic [7:0] chans;
    logic [MEM_AW-1:0] base;
    logic to_mem;
    logic [23:0] burst_left;
    logic [23:0] trig_left;
    logic [23:0] dly_left;
    logic [7:0] tick_div;
    logic busy;
    logic bus_pend;
    logic fetch_pend;
    logic [MEM_AW:0] wr_ptr;
    logic [MEM_AW:0] rd_ptr;
    logic [DEPTH-1:0][31:0] fb;
    logic [HW-1:0] fhead;
    logic [CW-1:0] fcnt;
    logic pin_s1;
    logic pin_s2;
    logic pin_s3;
    logic aw_ok;
    logic w_ok;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic start;
  } mts_regs_type;

  mts_regs_type q;
  mts_regs_type d;

  logic do_wr;
  logic cfg_wr;
  logic pin_fall;
  logic push;
  logic pop;
  logic [31:0] push_data;
  logic mem_we;
  logic mem_re;
  logic [31:0] mem_rdata;
  logic [23:0] burst_len;
  logic [31:0] wv;
  logic [HW-1:0] tail;
  logic bus_set;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    d = q;
    d.start = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    push_data = 32'h0000_0000;
    mem_we = 1'b0;
    mem_re = 1'b0;
    cfg_wr = 1'b0;
    bus_set = 1'b0;
    wv = 32'h0000_0000;
    tail = HW'(q.fhead + HW'(q.fcnt));
    // pin passes two flops before the edge detector
    d.pin_s1 = trig_pin_in;
    d.pin_s2 = q.pin_s1;
    d.pin_s3 = q.pin_s2;
    pin_fall = q.pin_s3 & ~q.pin_s2;
    // microsecond enable for the delay counter
    d.tick_div = (q.tick_div == 8'(`MTS_TICK_CYCLES - 1)) ? 8'h00 : q.tick_div + 8'h01;
    // single channel scans or stand-alone use the sample count
    if (q.scan && q.chans > 8'h01)
      burst_len = {16'h0000, q.chans};
    else
      burst_len = q.samp_cnt;

    ////////////////////////////////////////////////////////////////////////
    // axi write: address and data taken in either order
    if (s_axi_awvalid && !q.aw_ok)
    begin
      d.aw_ok = 1'b1;
      d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !q.w_ok)
    begin
      d.w_ok = 1'b1;
      d.wdata = s_axi_wdata;
      d.wstrb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready)
      d.bvalid = 1'b0;
    do_wr = q.aw_ok && q.w_ok && !q.bvalid;
    if (do_wr)
    begin
      d.aw_ok = 1'b0;
      d.w_ok = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = `MTS_RESP_OKAY;
      if (q.awaddr == `MTS_OFF_CTRL)
      begin
        if (q.wstrb[0] && q.wdata[`MTS_CMD_CONFIGURE])
        begin
          cfg_wr = 1'b1;
          d.src = internal_immediate_source;
          d.samp_cnt = `MTS_RST_COUNT;
          d.trig_cnt = `MTS_RST_COUNT;
          d.delay_us = `MTS_RST_DELAY;
          d.scan = q.wdata[`MTS_CMD_SCAN];
        end
        if (q.wstrb[0] && q.wdata[`MTS_CMD_BUS_TRIG])
        begin
          bus_set = 1'b1;
          d.bus_pend = 1'b1;
        end
      end
      else if (q.awaddr == `MTS_OFF_SRC)
      begin
        wv = merge({30'h0, q.src}, q.wdata, q.wstrb);
        d.src = mts_src_type'(wv[1:0]);
      end
      else if (q.awaddr == `MTS_OFF_SAMP)
      begin
        wv = merge({8'h00, q.samp_cnt}, q.wdata, q.wstrb);
        if (wv[23:0] != 24'h000000)
          d.samp_cnt = wv[23:0];
      end
      else if (q.awaddr == `MTS_OFF_TRIG)
      begin
        wv = merge({8'h00, q.trig_cnt}, q.wdata, q.wstrb);
        if (wv[23:0] != 24'h000000)
          d.trig_cnt = wv[23:0];
      end
      else if (q.awaddr == `MTS_OFF_DELAY)
      begin
        wv = merge({8'h00, q.delay_us}, q.wdata, q.wstrb);
        d.delay_us = (wv[23:0] > `MTS_MAX_DELAY_US) ? `MTS_MAX_DELAY_US : wv[23:0];
      end
      else if (q.awaddr == `MTS_OFF_BASE)
      begin
        wv = merge({{(32-MEM_AW){1'b0}}, q.base}, q.wdata, q.wstrb);
        d.base = wv[MEM_AW+1:2];
      end
      else if (q.awaddr == `MTS_OFF_CHANS)
      begin
        wv = merge({24'h000000, q.chans}, q.wdata, q.wstrb);
        d.chans = (wv[7:0] == 8'h00) ? `MTS_RST_CHANS : wv[7:0];
      end
      else
        d.bresp = `MTS_RESP_SLVERR;
    end

    ////////////////////////////////////////////////////////////////////////
    // axi read: data register read pops the output buffer
    if (q.rvalid && s_axi_rready)
      d.rvalid = 1'b0;
    if (s_axi_arvalid && !q.rvalid)
    begin
      d.rvalid = 1'b1;
      d.rresp = `MTS_RESP_OKAY;
      d.rdata = 32'h0000_0000;
      if (s_axi_araddr == `MTS_OFF_SRC)
        d.rdata = {30'h0, q.src};
      else if (s_axi_araddr == `MTS_OFF_SAMP)
        d.rdata = {8'h00, q.samp_cnt};
      else if (s_axi_araddr == `MTS_OFF_TRIG)
        d.rdata = {8'h00, q.trig_cnt};
      else if (s_axi_araddr == `MTS_OFF_DELAY)
        d.rdata = {8'h00, q.delay_us};
      else if (s_axi_araddr == `MTS_OFF_STATUS)
        d.rdata = {20'h00000, 4'(q.fcnt), 1'b0, q.scan, q.to_mem, q.st};
      else if (s_axi_araddr == `MTS_OFF_DATA)
      begin
        d.rdata = q.fb[q.fhead];
        pop = (q.fcnt != '0);
      end
      else if (s_axi_araddr == `MTS_OFF_BASE)
        d.rdata = 32'({q.base, 2'b00});
      else if (s_axi_araddr == `MTS_OFF_STORED)
        d.rdata = 32'({q.wr_ptr, 2'b00});
      else if (s_axi_araddr == `MTS_OFF_CHANS)
        d.rdata = {24'h000000, q.chans};
      else if (s_axi_araddr != `MTS_OFF_CTRL)
        d.rresp = `MTS_RESP_SLVERR;
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer
    case (q.st)
      ST_IDLE:
      begin
        d.bus_pend = 1'b0;
        if (do_wr && q.awaddr == `MTS_OFF_CTRL && q.wstrb[0])
        begin
          if (q.wdata[`MTS_CMD_INIT] || q.wdata[`MTS_CMD_READ])
          begin
            d.to_mem = q.wdata[`MTS_CMD_INIT];
            d.trig_left = q.trig_cnt;
            d.st = ST_WAIT;
            if (q.wdata[`MTS_CMD_INIT])
              d.wr_ptr = '0;
          end
          else if (q.wdata[`MTS_CMD_FETCH] && q.wr_ptr != '0)
          begin
            d.rd_ptr = '0;
            d.st = ST_FETCH;
          end
        end
      end
      ST_WAIT:
      begin
        if (q.src == internal_immediate_source
            || (q.src == external_edge_source && pin_fall)
            || (q.src == bus_command_source && q.bus_pend))
        begin
          // a bus trigger written in this very cycle wins over the clear
          d.bus_pend = bus_set;
          d.burst_left = burst_len;
          d.dly_left = q.delay_us;
          d.st = (q.delay_us == 24'h000000) ? ST_MEAS : ST_DELAY;
        end
      end
      ST_DELAY:
      begin
        if (q.tick_div == 8'h00)
        begin
          d.dly_left = q.dly_left - 24'h000001;
          if (q.dly_left == 24'h000001)
            d.st = ST_MEAS;
        end
      end
      ST_MEAS:
      begin
        // one reading in flight, so a free slot at start stays free
        if (!q.busy)
        begin
          if (q.to_mem || q.fcnt != CW'(DEPTH))
          begin
            d.start = 1'b1;
            d.busy = 1'b1;
          end
        end
        else if (rdg_valid)
        begin
          d.busy = 1'b0;
          if (q.to_mem)
          begin
            // memory full: further readings are dropped, not wrapped
            mem_we = !q.wr_ptr[MEM_AW];
            d.wr_ptr = q.wr_ptr + (MEM_AW+1)'(mem_we);
          end
          else
          begin
            push = 1'b1;
            push_data = rdg_data;
          end
          d.burst_left = q.burst_left - 24'h000001;
          if (q.burst_left == 24'h000001)
          begin
            d.trig_left = q.trig_left - 24'h000001;
            d.st = (q.trig_left == 24'h000001) ? ST_IDLE : ST_WAIT;
          end
        end
      end
      ST_FETCH:
      begin
        if (q.fetch_pend)
        begin
          push = 1'b1;
          push_data = mem_rdata;
          d.fetch_pend = 1'b0;
          d.rd_ptr = q.rd_ptr + 1'b1;
          if (q.rd_ptr + 1'b1 == q.wr_ptr)
            d.st = ST_IDLE;
        end
        else if (q.fcnt != CW'(DEPTH))
        begin
          mem_re = 1'b1;
          d.fetch_pend = 1'b1;
        end
      end
      default:
        d.st = ST_IDLE;
    endcase

    // output buffer bookkeeping
    if (push)
      d.fb[tail] = push_data;
    if (pop)
      d.fhead = q.fhead + 1'b1;
    d.fcnt = q.fcnt + CW'(push) - CW'(pop);
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q <= '0;
      q.st <= ST_IDLE;
      q.src <= internal_immediate_source;
      q.samp_cnt <= `MTS_RST_COUNT;
      q.trig_cnt <= `MTS_RST_COUNT;
      q.delay_us <= `MTS_RST_DELAY;
      q.chans <= `MTS_RST_CHANS;
      q.pin_s1 <= 1'b1;
      q.pin_s2 <= 1'b1;
      q.pin_s3 <= 1'b1;
    end
    else
      q <= d;
  end

  mts_reading_mem #(.AW(MEM_AW), .DW(32)) u_mem (
    .aclk(aclk),
    .we(mem_we),
    .waddr(MEM_AW'(q.base + q.wr_ptr[MEM_AW-1:0])),
    .wdata(rdg_data),
    .re(mem_re),
    .raddr(MEM_AW'(q.base + q.rd_ptr[MEM_AW-1:0])),
    .rdata(mem_rdata)
  );

  assign s_axi_awready = !q.aw_ok;
  assign s_axi_wready = !q.w_ok;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign meas_start = q.start;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_pin_edge;
    q.st == ST_WAIT && q.src == external_edge_source && pin_fall && q.delay_us == 24'h0
      |=> q.st == ST_MEAS;
  endproperty
  a_pin_edge: assert property (p_pin_edge) else $error("pin edge missed");

  property p_hold;
    q.st == ST_WAIT && q.src == hold_source |=> q.st == ST_WAIT;
  endproperty
  a_hold: assert property (p_hold) else $error("hold source fired");

  property p_cfg_src;
    cfg_wr |=> q.src == internal_immediate_source;
  endproperty
  a_cfg_src: assert property (p_cfg_src) else $error("configure source wrong");

  property p_cfg_counts;
    cfg_wr |=> q.samp_cnt == 24'h1 && q.trig_cnt == 24'h1 && q.delay_us == 24'h0;
  endproperty
  a_cfg_counts: assert property (p_cfg_counts) else $error("configure counts wrong");

  property p_samp_nonzero;
    q.samp_cnt != 24'h0 && q.trig_cnt != 24'h0;
  endproperty
  a_samp_nonzero: assert property (p_samp_nonzero) else $error("zero count");

  property p_full_stall;
    q.fcnt == CW'(DEPTH) && !q.to_mem |-> !d.start ##1 q.fcnt <= CW'(DEPTH);
  endproperty
  a_full_stall: assert property (p_full_stall) else $error("start while full");

  property p_mem_route;
    q.st == ST_MEAS && q.busy && rdg_valid && q.to_mem && !q.wr_ptr[MEM_AW]
      |-> mem_we && !push ##1 q.wr_ptr == $past(q.wr_ptr) + 1'b1;
  endproperty
  a_mem_route: assert property (p_mem_route) else $error("memory route wrong");

  property p_fetch_idle;
    $rose(q.st == ST_FETCH) |-> $past(q.st) == ST_IDLE && !q.busy;
  endproperty
  a_fetch_idle: assert property (p_fetch_idle) else $error("fetch mid-sequence");

  property p_read_bypass;
    q.st == ST_MEAS && q.busy && rdg_valid && !q.to_mem |-> push && !mem_we;
  endproperty
  a_read_bypass: assert property (p_read_bypass) else $error("read not bypassed");

endmodule

// [rtl/mts_defines.svh]
`ifndef MTS_DEFINES_SVH
`define MTS_DEFINES_SVH

// register byte offsets
`define MTS_OFF_CTRL 8'h00
`define MTS_OFF_SRC 8'h04
`define MTS_OFF_SAMP 8'h08
`define MTS_OFF_TRIG 8'h0C
`define MTS_OFF_DELAY 8'h10
`define MTS_OFF_STATUS 8'h14
`define MTS_OFF_DATA 8'h18
`define MTS_OFF_BASE 8'h1C
`define MTS_OFF_STORED 8'h20
`define MTS_OFF_CHANS 8'h24

// command bits of the control register
`define MTS_CMD_CONFIGURE 0
`define MTS_CMD_INIT 1
`define MTS_CMD_READ 2
`define MTS_CMD_FETCH 3
`define MTS_CMD_BUS_TRIG 4
`define MTS_CMD_SCAN 5

// reset and configure values
`define MTS_RST_COUNT 24'h000001
`define MTS_RST_DELAY 24'h000000
`define MTS_RST_CHANS 8'h01
`define MTS_MAX_COUNT 24'hFFFFFF

// delay is counted in microseconds, 16.7 s at most
`define MTS_CLK_PERIOD_NS 5
`define MTS_TICK_NS 1000
`define MTS_TICK_CYCLES (`MTS_TICK_NS / `MTS_CLK_PERIOD_NS)
`define MTS_MAX_DELAY_US 24'hFED260

// axi responses
`define MTS_RESP_OKAY 2'h0
`define MTS_RESP_SLVERR 2'h2

`endif

// [rtl/mts_pkg.sv]
package mts_pkg;

  typedef enum logic [4:0]
  {
    ST_IDLE = 5'h01,
    ST_WAIT = 5'h02,
    ST_DELAY = 5'h04,
    ST_MEAS = 5'h08,
    ST_FETCH = 5'h10
  } mts_state_type;

  typedef enum logic [1:0]
  {
    internal_immediate_source = 2'h0,
    external_edge_source = 2'h1,
    bus_command_source = 2'h2,
    hold_source = 2'h3
  } mts_src_type;

endpackage

// [rtl/mts_reading_mem.sv]
`timescale 1ns/1ps

module mts_reading_mem
  import mts_pkg::*;
#(
  parameter int AW = 10,
  parameter int DW = 32
)
(
  input wire logic aclk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic re,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);

  // no reset on the array: contents are only valid once written
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge aclk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    if (re)
    begin
      rdata <= mem[raddr];
    end
  end

endmodule

// [verif/mts_analog_model.sv]
`timescale 1ns/1ps

// stands in for the analog path: one reading per start, fast or slow
module mts_analog_model
(
  input wire logic aclk,
  input wire logic slow,
  input wire logic meas_start,
  output logic rdg_valid = 1'b0,
  output logic [31:0] rdg_data = 32'h0
);
  int cnt = 0;
  int wait_c = -1;
  logic [31:0] hold;

  always @(posedge aclk)
  begin
    if (meas_start)
    begin
      rdg_valid <= 1'b0;
      rdg_data <= ~rdg_data;
      hold = 32'h5A00_0000 + cnt;
      cnt++;
      wait_c = slow ? 4 : 0;
    end
    else if (wait_c == 0)
    begin
      rdg_valid <= 1'b1;
      rdg_data <= hold;
      wait_c = -1;
    end
    else
    begin
      rdg_valid <= 1'b0;
      // data toggles when not valid, so a stale capture shows up
      rdg_data <= ~rdg_data;
      if (wait_c > 0)
        wait_c--;
    end
  end
endmodule

// [verif/mts_sequencer_tb.sv]
`timescale 1ns/1ps
`include "mts_defines.svh"

module mts_sequencer_tb
  import mts_pkg::*;
;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  localparam logic [31:0] ST = 32'h0000_001F;
  localparam logic [31:0] CNT = 32'h0000_0F00;
  localparam logic [31:0] RB = 32'h5A00_0000;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic trig_pin_in = 1'b1;
  logic slow = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rdg_data, rd_q;
  logic meas_start, rdg_valid;
  int n_fail = 0, checked = 0, n_start = 0, cyc = 0, s0 = 0;

  always #2.5 aclk = ~aclk;

  mts_sequencer dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .trig_pin_in, .meas_start, .rdg_valid, .rdg_data);

  mts_analog_model model (.aclk, .slow, .meas_start, .rdg_valid, .rdg_data);

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (aresetn && meas_start)
      n_start <= n_start + 1;
    // whole run needs well under this
    if (cyc == 20000)
    begin
      n_fail++;
      conclude();
    end
  end

  task automatic conclude();
    $display("counts: checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      // negedge sample equals the value seen by the next rising edge
      @(negedge aclk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge aclk);
      if (aw)
        s_axi_awvalid <= 1'b0;
      if (w)
        s_axi_wvalid <= 1'b0;
    end
    while (!b);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic ar, v;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(negedge aclk);
      ar = s_axi_arvalid && s_axi_arready;
      v = s_axi_rvalid;
      d = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge aclk);
      if (ar)
        s_axi_arvalid <= 1'b0;
    end
    while (!v);
    s_axi_rready <= 1'b0;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a, rd_q);
    chk(rd_q & m, e);
  endtask

  task automatic cmd(input int b);
    wr(`MTS_OFF_CTRL, 32'h1 << b);
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic idle();
    int i;
    i = 0;
    do
    begin
      rd(`MTS_OFF_STATUS, rd_q);
      i++;
    end
    while (rd_q[4:0] !== 5'h01 && i < 400);
    // running out of polls counts as a mismatch
    chk(rd_q[4:0], 32'h1);
  endtask

  // each pop must return readings in the order they were taken
  task automatic pops(input int n);
    for (int k = 0; k < n; k++)
      rc(`MTS_OFF_DATA, ALL, RB + s0 + k);
  endtask

  task automatic start_read();
    s0 = n_start;
    cmd(`MTS_CMD_READ);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rc(`MTS_OFF_SRC, ALL, 32'h0);
    rc(`MTS_OFF_SAMP, ALL, 32'h1);
    rc(`MTS_OFF_TRIG, ALL, 32'h1);
    rc(`MTS_OFF_DELAY, ALL, 32'h0);
    rc(`MTS_OFF_STATUS, ST, 32'h1);
    wr(8'h40, 32'h1);
    chk(resp, `MTS_RESP_SLVERR);
    rd(8'h40, rd_q);
    chk(resp, `MTS_RESP_SLVERR);
    wr(`MTS_OFF_SAMP, 32'h0);
    rc(`MTS_OFF_SAMP, ALL, 32'h1);
    wr(`MTS_OFF_SAMP, 32'h00FF_FFFF);
    rc(`MTS_OFF_SAMP, ALL, 32'h00FF_FFFF);
    wr(`MTS_OFF_TRIG, 32'h00FF_FFFF);
    rc(`MTS_OFF_TRIG, ALL, 32'h00FF_FFFF);
    wr(`MTS_OFF_DELAY, 32'h00FF_FFFF);
    rc(`MTS_OFF_DELAY, ALL, `MTS_MAX_DELAY_US);
    $display("t_reset done");
  endtask

  task automatic t_config();
    wr(`MTS_OFF_SRC, bus_command_source);
    wr(`MTS_OFF_DELAY, 32'h7);
    cmd(`MTS_CMD_CONFIGURE);
    rc(`MTS_OFF_SRC, ALL, 32'h0);
    rc(`MTS_OFF_SAMP, ALL, 32'h1);
    rc(`MTS_OFF_TRIG, ALL, 32'h1);
    rc(`MTS_OFF_DELAY, ALL, 32'h0);
    $display("t_config done");
  endtask

  task automatic t_read();
    slow <= 1'b1;
    wr(`MTS_OFF_SAMP, 32'h3);
    start_read();
    idle();
    rc(`MTS_OFF_STATUS, CNT | 32'h20, 32'h300);
    pops(3);
    slow <= 1'b0;
    $display("t_read done");
  endtask

  task automatic t_full();
    wr(`MTS_OFF_SAMP, 32'hA);
    start_read();
    cycles(300);
    chk(n_start - s0, 32'h8);
    rc(`MTS_OFF_STATUS, CNT, 32'h800);
    pops(10);
    idle();
    $display("t_full done");
  endtask

  task automatic t_ext();
    wr(`MTS_OFF_SAMP, 32'h1);
    wr(`MTS_OFF_SRC, external_edge_source);
    // a fall while idle, then a rise, must not start anything
    trig_pin_in <= 1'b0;
    start_read();
    trig_pin_in <= 1'b1;
    cycles(100);
    chk(n_start - s0, 32'h0);
    trig_pin_in <= 1'b0;
    cycles(4);
    trig_pin_in <= 1'b1;
    idle();
    chk(n_start - s0, 32'h1);
    pops(1);
    $display("t_ext done");
  endtask

  task automatic t_bus();
    wr(`MTS_OFF_SRC, bus_command_source);
    wr(`MTS_OFF_TRIG, 32'h2);
    wr(`MTS_OFF_SAMP, 32'h2);
    start_read();
    cycles(50);
    chk(n_start - s0, 32'h0);
    cmd(`MTS_CMD_BUS_TRIG);
    cycles(50);
    chk(n_start - s0, 32'h2);
    rc(`MTS_OFF_STATUS, ST, 32'h2);
    cmd(`MTS_CMD_BUS_TRIG);
    idle();
    chk(n_start - s0, 32'h4);
    pops(4);
    $display("t_bus done");
  endtask

  task automatic t_hold();
    wr(`MTS_OFF_SRC, hold_source);
    wr(`MTS_OFF_TRIG, 32'h1);
    start_read();
    cycles(100);
    chk(n_start - s0, 32'h0);
    // hold never fires, so only a reset, a source write or a configure gets back to idle
    aresetn <= 1'b0;
    cycles(16);
    aresetn <= 1'b1;
    rc(`MTS_OFF_STATUS, ST, 32'h1);
    rc(`MTS_OFF_SRC, ALL, 32'h0);
    $display("t_hold done");
  endtask

  task automatic t_delay();
    int i;
    i = 0;
    wr(`MTS_OFF_DELAY, 32'h2);
    start_read();
    while (n_start == s0 && i < 1000)
    begin
      @(negedge aclk);
      i++;
    end
    // 1 us tick of 200 cycles, so 2 us lands between one and two ticks
    chk(i >= 190 && i <= 420, 32'h1);
    idle();
    pops(1);
    $display("t_delay done");
  endtask

  task automatic t_scan();
    wr(`MTS_OFF_CHANS, 32'h1);
    wr(`MTS_OFF_CTRL, (32'h1 << `MTS_CMD_CONFIGURE) | (32'h1 << `MTS_CMD_SCAN));
    rc(`MTS_OFF_STATUS, 32'h40, 32'h40);
    wr(`MTS_OFF_SAMP, 32'h3);
    start_read();
    idle();
    chk(n_start - s0, 32'h3);
    pops(3);
    // several channels: the channel count sets the burst, not the sample count
    wr(`MTS_OFF_CHANS, 32'h2);
    start_read();
    idle();
    chk(n_start - s0, 32'h2);
    pops(2);
    cmd(`MTS_CMD_CONFIGURE);
    rc(`MTS_OFF_STATUS, 32'h40, 32'h0);
    $display("t_scan done");
  endtask

  task automatic t_mem();
    cmd(`MTS_CMD_CONFIGURE);
    wr(`MTS_OFF_SAMP, 32'h4);
    wr(`MTS_OFF_BASE, 32'h0);
    s0 = n_start;
    cmd(`MTS_CMD_INIT);
    idle();
    rc(`MTS_OFF_STATUS, CNT | 32'h20, 32'h20);
    rc(`MTS_OFF_STORED, ALL, 32'h10);
    // an empty buffer answers with stale data, but must not pop
    rd(`MTS_OFF_DATA, rd_q);
    chk(resp, `MTS_RESP_OKAY);
    rc(`MTS_OFF_STATUS, CNT, 32'h0);
    cmd(`MTS_CMD_FETCH);
    idle();
    pops(4);
    $display("t_mem done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    cycles(16);
    aresetn <= 1'b1;
    t_reset();
    t_config();
    t_read();
    t_full();
    t_ext();
    t_bus();
    t_hold();
    t_delay();
    t_scan();
    t_mem();
    conclude();
  end
endmodule
